// [rtl/poll_io_device.sv]
// Purpose: Device end: decodes command assemblies and builds responses
// Assumes: Motion state arrives as same-clock levels from the motion core
// Notes:   Response is issued one cycle after each command
`timescale 1ns/1ps
module poll_io_device #(
  parameter int unsigned AXIS_W = 3
) (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // Motion state
  input  wire logic [31:0] act_pos_in,
  input  wire logic [31:0] cmd_pos_in,
  input  wire logic [31:0] act_vel_in,
  input  wire logic [7:0]  status_in,
  // Status bits: 0 home, 1 dir, 2 fault, 3 on target, 4 busy,
  // 5 following err, 6 ccw, 7 cw; fault input separate
  input  wire logic        fault_pin_in,
  // Control to motion core
  output logic             enable_out,
  output logic             hard_stop_out,
  output logic             smooth_stop_out,
  output logic             dir_out,
  output logic             incr_out,
  output logic             sl_enable_out,
  output logic [7:0]       sl_action_out,
  output logic [31:0]      sl_pos_out,
  output logic [31:0]      sl_neg_out,
  output logic [31:0]      init_vel_out,
  // Link
  poll_io_if.device        link
);
  logic [7:0] cb [poll_io_pkg::ASM_BYTES];
  genvar g;
  generate
    for (g = 0; g < poll_io_pkg::ASM_BYTES; g++) begin : g_split
      assign cb[g] = link.cmd_data[8*g +: 8];
    end
  endgenerate

  function automatic logic attr_known(input logic [7:0] a);
    attr_known = (a == poll_io_pkg::ATTR_SL_ENABLE) || (a == poll_io_pkg::ATTR_SL_ACTION) ||
                 (a == poll_io_pkg::ATTR_SL_POS) || (a == poll_io_pkg::ATTR_SL_NEG) ||
                 (a == poll_io_pkg::ATTR_INIT_VEL);
  endfunction : attr_known

  // Load edge and last control bits
  logic        load_prev_r;
  logic [4:0]  ctl_r;
  // Stored attributes
  logic        sl_en_r;
  logic [7:0]  sl_act_r;
  logic [31:0] sl_pos_r;
  logic [31:0] sl_neg_r;
  logic [31:0] ivel_r;
  // Response and its strobe
  logic [63:0] rsp_r;
  logic        rsp_v_r;
  // Fault input after two synchroniser flops
  logic        fault_meta_r;
  logic        fault_sync_r;

  wire [4:0]  cmd_type  = cb[2][poll_io_pkg::TYPE_W-1:0];
  wire [2:0]  cmd_axis  = cb[2][7:poll_io_pkg::AXIS_LSB];
  wire [31:0] value     = {cb[7], cb[6], cb[5], cb[4]};
  wire        load_bit  = cb[0][poll_io_pkg::CB0_LOAD];
  wire        is_attr   = (cmd_type == poll_io_pkg::TYPE_ATTR);
  wire        is_poll   = (cmd_type == poll_io_pkg::TYPE_ACT_POS) ||
                          (cmd_type == poll_io_pkg::TYPE_CMD_POS) ||
                          (cmd_type == poll_io_pkg::TYPE_ACT_VEL);
  // Boolean attribute accepts only 0/1
  wire        val_ok    = (cb[3] != poll_io_pkg::ATTR_SL_ENABLE) || (value[31:1] == 31'h0000_0000);
  wire        attr_ok   = attr_known(cb[1]) && attr_known(cb[3]) && val_ok;
  wire        bad       = !is_poll && !(is_attr && attr_ok);
  wire        do_write  = link.cmd_valid && is_attr && attr_ok && load_bit && !load_prev_r;
  wire        type_bad  = !is_attr && !is_poll;
  // Type error outranks a value error, which outranks an attribute error
  wire [7:0]  err_code  = type_bad ? poll_io_pkg::ERR_BAD_TYPE :
                          !val_ok ? poll_io_pkg::ERR_BAD_VALUE : poll_io_pkg::ERR_BAD_ATTR;

  // One write strobe per attribute
  wire        wr_sl_en  = do_write && (cb[3] == poll_io_pkg::ATTR_SL_ENABLE);
  wire        wr_sl_act = do_write && (cb[3] == poll_io_pkg::ATTR_SL_ACTION);
  wire        wr_sl_pos = do_write && (cb[3] == poll_io_pkg::ATTR_SL_POS);
  wire        wr_sl_neg = do_write && (cb[3] == poll_io_pkg::ATTR_SL_NEG);
  wire        wr_ivel   = do_write && (cb[3] == poll_io_pkg::ATTR_INIT_VEL);

  // Attribute readback, showing the value after a write in the same command
  wire [31:0] nv_sl_en  = wr_sl_en ? {31'h0000_0000, value[0]} : {31'h0000_0000, sl_en_r};
  wire [31:0] nv_sl_act = wr_sl_act ? {24'h00_0000, value[7:0]} : {24'h00_0000, sl_act_r};
  wire [31:0] nv_sl_pos = wr_sl_pos ? value : sl_pos_r;
  wire [31:0] nv_sl_neg = wr_sl_neg ? value : sl_neg_r;
  wire [31:0] nv_ivel   = wr_ivel ? value : ivel_r;
  wire [31:0] get_val   = (cb[1] == poll_io_pkg::ATTR_SL_ENABLE) ? nv_sl_en :
                          (cb[1] == poll_io_pkg::ATTR_SL_ACTION) ? nv_sl_act :
                          (cb[1] == poll_io_pkg::ATTR_SL_POS)    ? nv_sl_pos :
                          (cb[1] == poll_io_pkg::ATTR_SL_NEG)    ? nv_sl_neg : nv_ivel;

  // Status levels from the motion core
  wire        st_home   = status_in[0];
  wire        st_dir    = status_in[1];
  wire        st_fault  = status_in[2];
  wire        st_target = status_in[3];
  wire        st_busy   = status_in[4];
  wire        st_follow = status_in[5];
  wire        st_ccw    = status_in[6];
  wire        st_cw     = status_in[7];

  // Limit flags use the stored limits, not a value written by this command
  wire        sw_neg    = sl_en_r && ($signed(act_pos_in) <= $signed(sl_neg_r));
  wire        sw_pos    = sl_en_r && ($signed(act_pos_in) >= $signed(sl_pos_r));

  // Enable is reported as set by the command being answered
  wire        en_now    = cb[0][poll_io_pkg::CB0_ENABLE];
  wire [4:0]  ctl_nxt   = {cb[0][poll_io_pkg::CB0_ENABLE], cb[0][poll_io_pkg::CB0_HSTOP],
                           cb[0][poll_io_pkg::CB0_SSTOP], cb[0][poll_io_pkg::CB0_DIR],
                           cb[0][poll_io_pkg::CB0_INCR]};
  wire [7:0]  sb0       = {en_now, 1'b0, st_home, st_dir, st_fault, st_target, 1'b0, st_busy};
  // Load complete always set: a write finishes in the cycle it is taken
  wire [7:0]  sb2       = {1'b1, 1'b0, st_follow, sw_neg, sw_pos, st_ccw, st_cw, fault_sync_r};
  wire [4:0]  rsp_type  = bad ? poll_io_pkg::TYPE_ERROR : cmd_type;
  wire [7:0]  sb3       = {cmd_axis, rsp_type};
  // Byte 1 undefined for poll types; zero is driven there
  wire [31:0] poll_val  = (cmd_type == poll_io_pkg::TYPE_ACT_POS) ? act_pos_in :
                          (cmd_type == poll_io_pkg::TYPE_CMD_POS) ? cmd_pos_in :
                          act_vel_in;
  wire [63:0] rsp_nxt   = bad     ? {cb[3], cb[2], 8'h00, err_code, sb3, sb2, 8'h00, sb0} :
                          is_attr ? {get_val, sb3, sb2, cb[1], sb0} :
                          {poll_val, sb3, sb2, 8'h00, sb0};

  // Two flops: the fault input is a pin from outside the clock domain
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fault_meta_r <= 1'b0;
      fault_sync_r <= 1'b0;
    end else begin
      fault_meta_r <= fault_pin_in;
      fault_sync_r <= fault_meta_r;
    end
  end

  // Answer one cycle after the command; data holds until the next answer
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rsp_v_r <= 1'b0;
      rsp_r   <= 64'h0000_0000_0000_0000;
    end else begin
      rsp_v_r <= link.cmd_valid;
      if (link.cmd_valid) begin
        rsp_r <= rsp_nxt;
      end
    end
  end

  // Load edge is tracked over every command, valid or not
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      load_prev_r <= 1'b0;
      ctl_r       <= 5'h00;
    end else if (link.cmd_valid) begin
      load_prev_r <= load_bit;
      ctl_r       <= ctl_nxt;
    end
  end

  // Stored attributes; limit and velocity reset values come from the package, enable and action reset to zero
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sl_en_r  <= 1'b0;
      sl_act_r <= 8'h00;
      sl_pos_r <= poll_io_pkg::RST_SL_POS;
      sl_neg_r <= poll_io_pkg::RST_SL_NEG;
      ivel_r   <= poll_io_pkg::RST_INIT_VEL;
    end else begin
      sl_en_r  <= nv_sl_en[0];
      sl_act_r <= nv_sl_act[7:0];
      sl_pos_r <= nv_sl_pos;
      sl_neg_r <= nv_sl_neg;
      ivel_r   <= nv_ivel;
    end
  end

  assign link.rsp_valid  = rsp_v_r;
  assign link.rsp_data   = rsp_r;
  assign enable_out      = ctl_r[4];
  assign hard_stop_out   = ctl_r[3];
  assign smooth_stop_out = ctl_r[2];
  assign dir_out         = ctl_r[1];
  assign incr_out        = ctl_r[0];
  assign sl_enable_out   = sl_en_r;
  assign sl_action_out   = sl_act_r;
  assign sl_pos_out      = sl_pos_r;
  assign sl_neg_out      = sl_neg_r;
  assign init_vel_out    = ivel_r;
endmodule : poll_io_device

// [rtl/poll_io_if.sv]
// Purpose: Carrier joining the master and device ends of the poll link
// Assumes: Both ends on core_clk_in
// Notes:   cmd_valid / rsp_valid are high one cycle per command; a load pair holds them high two cycles
`timescale 1ns/1ps
interface poll_io_if;
  logic        cmd_valid;
  logic [63:0] cmd_data;
  logic        rsp_valid;
  logic [63:0] rsp_data;
  modport master (output cmd_valid, output cmd_data, input rsp_valid, input rsp_data);
  modport device (input cmd_valid, input cmd_data, output rsp_valid, output rsp_data);
endinterface : poll_io_if

// [rtl/poll_io_master.sv]
// Purpose: Master end: sends command assemblies, captures responses
// Assumes: Software register port with read data one cycle later
// Notes:   Registers: 0 cmd low, 1 cmd high, 2 send/status, 3 rsp low, 4 rsp high
`timescale 1ns/1ps
module poll_io_master (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // Software port
  input  wire logic [2:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  // Link
  poll_io_if.master        link
);
  localparam logic [2:0] REG_CMD_LO = 3'h0;
  localparam logic [2:0] REG_CMD_HI = 3'h1;
  localparam logic [2:0] REG_CTRL   = 3'h2;
  localparam logic [2:0] REG_RSP_LO = 3'h3;
  localparam logic [2:0] REG_RSP_HI = 3'h4;

  logic [63:0] cmd_r;
  logic [63:0] rsp_r;
  logic        valid_r;
  logic        rsp_new_r;
  logic        pulse_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_mux;
  wire         send_w  = wr_in && (addr_in == REG_CTRL) && wdata_in[0];
  // Writing bit 1 of control sends a load pair: bit 0 low, then high
  wire         pair_w  = wr_in && (addr_in == REG_CTRL) && wdata_in[1];
  logic        pair_r;

  assign rd_mux = (addr_in == REG_CMD_LO) ? cmd_r[31:0] :
                  (addr_in == REG_CMD_HI) ? cmd_r[63:32] :
                  (addr_in == REG_CTRL)   ? {31'h0000_0000, rsp_new_r} :
                  (addr_in == REG_RSP_LO) ? rsp_r[31:0] :
                  (addr_in == REG_RSP_HI) ? rsp_r[63:32] : 32'h0000_0000;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_r     <= 64'h0000_0000_0000_0000;
      rsp_r     <= 64'h0000_0000_0000_0000;
      valid_r   <= 1'b0;
      rsp_new_r <= 1'b0;
      pair_r    <= 1'b0;
      rdata_r   <= 32'h0000_0000;
    end else begin
      valid_r <= 1'b0;
      if (wr_in && addr_in == REG_CMD_LO) cmd_r[31:0]  <= wdata_in;
      if (wr_in && addr_in == REG_CMD_HI) cmd_r[63:32] <= wdata_in;
      if (pair_w) begin
        cmd_r[poll_io_pkg::CB0_LOAD] <= 1'b0;
        valid_r <= 1'b1;
        pair_r  <= 1'b1;
      end else if (pair_r) begin
        cmd_r[poll_io_pkg::CB0_LOAD] <= 1'b1;
        valid_r <= 1'b1;
        pair_r  <= 1'b0;
      end else if (send_w) begin
        valid_r <= 1'b1;
      end
      // Set wins over read-clear
      if (link.rsp_valid) begin
        rsp_r     <= link.rsp_data;
        rsp_new_r <= 1'b1;
      end else if (rd_in && addr_in == REG_CTRL) begin
        rsp_new_r <= 1'b0;
      end
      rdata_r <= rd_in ? rd_mux : 32'h0000_0000;
    end
  end

  assign link.cmd_valid = valid_r;
  assign link.cmd_data  = cmd_r;
  assign rdata_out      = rdata_r;
endmodule : poll_io_master

// [rtl/poll_io_pkg.sv]
// Purpose: Shared constants for the eight-byte polled IO assembly link
// Assumes: One clock, asynchronous active-high reset
// Notes:   Assemblies travel as 64-bit words, byte 0 in bits 7:0
package poll_io_pkg;
  localparam int unsigned ASM_BYTES         = 8;
  localparam int unsigned ASM_W             = 64;
  // Command byte 0 bit positions
  localparam int unsigned CB0_LOAD          = 0;
  localparam int unsigned CB0_INCR          = 2;
  localparam int unsigned CB0_DIR           = 3;
  localparam int unsigned CB0_SSTOP         = 4;
  localparam int unsigned CB0_HSTOP         = 5;
  localparam int unsigned CB0_ENABLE        = 7;
  // Byte 2/3 split: axis in 7:5, type in 4:0
  localparam int unsigned AXIS_LSB          = 5;
  localparam int unsigned TYPE_W            = 5;
  // Message types
  localparam logic [4:0]  TYPE_ACT_POS      = 5'h01;
  localparam logic [4:0]  TYPE_CMD_POS      = 5'h02;
  localparam logic [4:0]  TYPE_ACT_VEL      = 5'h03;
  localparam logic [4:0]  TYPE_ERROR        = 5'h14;
  localparam logic [4:0]  TYPE_ATTR         = 5'h1B;
  // Attribute numbers of class 0x25
  localparam logic [7:0]  ATTR_SL_ENABLE    = 8'h34;
  localparam logic [7:0]  ATTR_SL_ACTION    = 8'h35;
  localparam logic [7:0]  ATTR_SL_POS       = 8'h36;
  localparam logic [7:0]  ATTR_SL_NEG       = 8'h37;
  localparam logic [7:0]  ATTR_INIT_VEL     = 8'h6E;
  // Error codes for the error response
  localparam logic [7:0]  ERR_BAD_ATTR      = 8'h09;
  localparam logic [7:0]  ERR_BAD_VALUE     = 8'h20;
  localparam logic [7:0]  ERR_BAD_TYPE      = 8'h08;
  // Reset values
  localparam logic [31:0] RST_INIT_VEL      = 32'h0000_0000;
  localparam logic [31:0] RST_SL_POS        = 32'h0000_0000;
  localparam logic [31:0] RST_SL_NEG        = 32'h0000_0000;
endpackage : poll_io_pkg

// [testbench/motion_poll_io_assembly_asserts.sv]
// Purpose: Link checks between master and device ends
// Assumes: One clock, reset active high
// Notes:   Watches the carrier signals only
`timescale 1ns/1ps
module motion_poll_io_assembly_asserts (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // Link
  input  wire logic        cmd_valid,
  input  wire logic [63:0] cmd_data,
  input  wire logic        rsp_valid,
  input  wire logic [63:0] rsp_data
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  wire [4:0] cmd_type = cmd_data[20:16];
  wire [4:0] rsp_type = rsp_data[28:24];
  wire       poll_ok  = cmd_type inside {5'h01, 5'h02, 5'h03};
  wire       bad_type = !poll_ok && cmd_type != poll_io_pkg::TYPE_ATTR;
  rsp_timing_a: assert property (cmd_valid |=> rsp_valid) else $error("response missing");
  rsp_cause_a: assert property (rsp_valid |-> $past(cmd_valid)) else $error("stray response");
  type_echo_a: assert property (cmd_valid && poll_ok |=> rsp_type == $past(cmd_type))
    else $error("wrong response type");
  bad_type_a: assert property (cmd_valid && bad_type |=> rsp_type == poll_io_pkg::TYPE_ERROR
    && rsp_data[39:32] == poll_io_pkg::ERR_BAD_TYPE) else $error("bad type not refused");
  err_copy_a: assert property (rsp_valid && rsp_type == poll_io_pkg::TYPE_ERROR
    |-> rsp_data[63:48] == $past(cmd_data[31:16])) else $error("error copy wrong");
  get_echo_a: assert property (rsp_valid && rsp_type == poll_io_pkg::TYPE_ATTR
    |-> rsp_data[15:8] == $past(cmd_data[15:8])) else $error("get attribute not echoed");
  poll_byte1_a: assert property (rsp_valid && rsp_type inside {5'h01, 5'h02, 5'h03}
    |-> rsp_data[15:8] == 8'h00) else $error("byte 1 not zero");
  load_pair_a: assert property (cmd_valid && !cmd_data[0] ##1 cmd_valid
    |-> cmd_data == ($past(cmd_data) | 64'h1)) else $error("load pair differs");
  rsp_hold_a: assert property (!rsp_valid |-> $stable(rsp_data)) else $error("response moved");
  load_done_a: assert property (rsp_valid && rsp_type != poll_io_pkg::TYPE_ERROR |-> rsp_data[23])
    else $error("load complete low");
endmodule : motion_poll_io_assembly_asserts

// [testbench/motion_poll_io_assembly_tb.sv]
// Purpose: Self-checking bench, master and device joined
// Assumes: Response register holds the last response
// Notes:   Model tracks attributes, limit flags and the load edge
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module motion_poll_io_assembly_tb;
  logic        core_clk_in, rst_in, wr_in, rd_in, fault_pin_in;
  logic [2:0]  addr_in;
  logic [31:0] wdata_in, rdata_out, act_pos_in, cmd_pos_in, act_vel_in, sl_pos_out, sl_neg_out, init_vel_out;
  logic [7:0]  status_in, sl_action_out, b0, ats [5];
  logic        enable_out, hard_stop_out, smooth_stop_out, dir_out, incr_out, sl_enable_out;
  logic [31:0] attr [logic [7:0]];
  logic [31:0] v;
  int unsigned seed_val;
  int          miscompares, cmp_count, prev_load;
  logic [159:0] attr_all;
  poll_io_if poll_io_if_inst ();
  poll_io_master poll_io_master_inst (.core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .link(poll_io_if_inst));
  poll_io_device poll_io_device_inst (.core_clk_in(core_clk_in), .rst_in(rst_in), .act_pos_in(act_pos_in),
    .cmd_pos_in(cmd_pos_in), .act_vel_in(act_vel_in), .status_in(status_in), .fault_pin_in(fault_pin_in),
    .enable_out(enable_out), .hard_stop_out(hard_stop_out), .smooth_stop_out(smooth_stop_out),
    .dir_out(dir_out), .incr_out(incr_out), .sl_enable_out(sl_enable_out), .sl_action_out(sl_action_out),
    .sl_pos_out(sl_pos_out), .sl_neg_out(sl_neg_out), .init_vel_out(init_vel_out), .link(poll_io_if_inst));
  motion_poll_io_assembly_asserts motion_poll_io_assembly_asserts_inst (.core_clk_in(core_clk_in),
    .rst_in(rst_in), .cmd_valid(poll_io_if_inst.cmd_valid), .cmd_data(poll_io_if_inst.cmd_data),
    .rsp_valid(poll_io_if_inst.rsp_valid), .rsp_data(poll_io_if_inst.rsp_data));
  // Expected response; updates attribute state like the device would
  function automatic logic [63:0] model(input logic [63:0] c);
    logic [7:0]  ty, g, s, code, x0, x2;
    logic [31:0] val;
    logic        sn, sp;
    ty = {3'h0, c[20:16]};
    g = c[15:8];
    s = c[31:24];
    code = 8'h00;
    sn = attr[8'h34][0] && ($signed(act_pos_in) <= $signed(attr[8'h37]));
    sp = attr[8'h34][0] && ($signed(act_pos_in) >= $signed(attr[8'h36]));
    x0 = {c[7], 1'b0, status_in[0], status_in[1], status_in[2], status_in[3], 1'b0, status_in[4]};
    x2 = {2'b10, status_in[5], sn, sp, status_in[6], status_in[7], fault_pin_in};
    if (ty == 8'h1B) begin
      if (s == 8'h34 && c[63:32] > 1) code = 8'h20;
      else if (!attr.exists(g) || !attr.exists(s)) code = 8'h09;
      else if (c[0] && prev_load == 0) attr[s] = c[63:32];
    end else if (ty == 8'h00 || ty > 8'h03) code = 8'h08;
    prev_load = int'(c[0]);
    if (code != 8'h00) return {c[31:16], 8'h00, code, c[23:21], 5'h14, x2, 8'h00, x0};
    val = (ty == 8'h01) ? act_pos_in : (ty == 8'h02) ? cmd_pos_in : (ty == 8'h03) ? act_vel_in : attr[g];
    return {val, c[23:16], x2, (ty == 8'h1B) ? g : 8'h00, x0};
  endfunction : model
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
    @(posedge core_clk_in);
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [31:0] d);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    @(negedge core_clk_in);
    d = rdata_out;
    @(posedge core_clk_in);
  endtask : rd
  task automatic test_done;
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // Pair mode sends bit 0 clear then set
  task automatic send(input logic [63:0] c, input bit pair);
    logic [63:0] exp;
    logic [31:0] lo, hi;
    int          n;
    if (pair) exp = model({c[63:1], 1'b0});
    exp = model(c);
    wr(3'h0, c[31:0]);
    wr(3'h1, c[63:32]);
    wr(3'h2, pair ? 32'h0000_0002 : 32'h0000_0001);
    lo = 32'h0000_0000;
    for (n = 0; n < 8 && lo[0] !== 1'b1; n++) rd(3'h2, lo);
    if (lo[0] !== 1'b1) begin miscompares++; test_done(); end
    rd(3'h3, lo);
    rd(3'h4, hi);
    `CHK("response", exp, {hi, lo})
    rd(3'h0, lo);
    `CHK("command readback", pair ? {c[31:1], 1'b1} : c[31:0], lo)
  endtask : send
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  initial begin
    {rst_in, wr_in, rd_in, addr_in, wdata_in, fault_pin_in} = {1'b1, 38'h0};
    {act_pos_in, cmd_pos_in, act_vel_in, status_in} = 104'h0;
    ats = '{8'h34, 8'h35, 8'h36, 8'h37, 8'h6E};
    foreach (ats[i]) attr[ats[i]] = 32'h0000_0000;
    prev_load = 0;
    seed_val = $urandom(50);
    repeat (10) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    for (int t = 0; t < 6; t++) begin
      {act_pos_in, cmd_pos_in, act_vel_in} <= {$urandom, $urandom, $urandom};
      {status_in, fault_pin_in} <= 9'($urandom);
      b0 = 8'($urandom) & 8'hBE;
      @(posedge core_clk_in);
      send({32'h0, 8'h00, 3'($urandom), 5'(t == 5 ? 8'h14 : t), 8'h00, b0}, 1'b0);
      `CHK("control", {b0[7], b0[5:2]}, {enable_out, hard_stop_out, smooth_stop_out, dir_out, incr_out})
    end
    foreach (ats[i]) begin
      v = (i == 0) ? $urandom % 2 : (i == 1) ? $urandom % 256 : $urandom;
      send({v, ats[i], 3'($urandom), 5'h1B, ats[(i + 1) % 5], 8'h81}, 1'b1);
    end
    send({$urandom, 8'h6E, 8'h3B, 8'h6E, 8'h81}, 1'b0);
    send({32'h0000_0001, 8'h99, 8'h3B, 8'h6E, 8'h81}, 1'b1);
    send({32'h0000_0002, 8'h34, 8'h3B, 8'h34, 8'h81}, 1'b1);
    send({32'h0000_0001, 8'h6E, 8'h3B, 8'h42, 8'h81}, 1'b1);
    attr_all = {31'h0000_0000, sl_enable_out, 24'h00_0000, sl_action_out, sl_pos_out, sl_neg_out, init_vel_out};
    `CHK("attributes", {attr[8'h34], attr[8'h35], attr[8'h36], attr[8'h37], attr[8'h6E]}, attr_all)
    test_done();
  end
endmodule : motion_poll_io_assembly_tb
